// ==== core/art_pkg.sv ====
// constants, register map and types of the auto-reload timer
package art_pkg;

    // ------------------------------------------------------------
    // register indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MODE = 8'hD5;
    localparam logic [7:0] IDX_FLAGS = 8'hD6;
    localparam logic [7:0] IDX_CLKSEL = 8'hD7;
    localparam logic [7:0] IDX_PRESCALER = 8'hD8;
    localparam logic [7:0] IDX_RELOAD = 8'hD9;
    localparam logic [7:0] IDX_COMPARE = 8'hDA;
    localparam logic [7:0] IDX_LIVE_LOAD = 8'hDB;

    // ------------------------------------------------------------
    // timer_mode_control fields
    // ------------------------------------------------------------
    localparam int BIT_LOAD = 7;
    localparam int BIT_RUN = 6;
    localparam int BIT_PWM_OE = 5;
    localparam int BIT_EDGE_IE = 4;
    localparam int BIT_MATCH_IE = 3;
    localparam int BIT_ROLL_IE = 2;
    localparam int MODE_LSB = 0;

    // ------------------------------------------------------------
    // timer_flags fields
    // ------------------------------------------------------------
    localparam int BIT_EDGE_FLAG = 2;
    localparam int BIT_MATCH_FLAG = 1;
    localparam int BIT_ROLL_FLAG = 0;

    // ------------------------------------------------------------
    // clock_edge_select fields
    // ------------------------------------------------------------
    localparam int PS_LSB = 5;
    localparam int BIT_RSVD = 4;
    localparam int BIT_EDGE_POL = 3;
    localparam int BIT_EDGE_EN = 2;
    localparam int CLK_LSB = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [1:0] DIV3_LAST = 2'h2;

    // operating modes in mode_select order
    typedef enum logic [1:0] {
        ART_AUTO_RELOAD,
        ART_CAPTURE,
        ART_CAPTURE_RESET,
        ART_EXT_LOAD
    } art_mode_type;

    // counting clock sources in clock_select order
    typedef enum logic [1:0] {
        ART_SRC_INT,
        ART_SRC_DIV3,
        ART_SRC_PIN,
        ART_SRC_RSVD
    } art_src_type;

endpackage : art_pkg

// ==== core/art_timer.sv ====
// auto-reload timer with prescaler, capture, compare and apb registers
`timescale 1ns/100ps
`default_nettype none

module art_timer #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic event_input_pin_i,
    output logic pwm_output_pin_o,
    output logic irq_req_o
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // true when a byte address selects a register index
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0] idx);
        addr_hit = (addr == ADDR_W'({idx, 2'b00}));
    endfunction : addr_hit

    // low bits of the prescaler that must be all ones for a tick
    function automatic logic [6:0] ps_mask(input logic [2:0] sel);
        ps_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction : ps_mask

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [6:0] mode_q, psc_q, psc_d;
    logic [7:0] cfg_q, reload_q, compare_q, cnt_q, cnt_d;
    logic [2:0] flags_q;
    logic [1:0] div3_q;
    logic evt_prev_q, pwm_q, pwm_pin_q, irq_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic apb_fire, wr, known, mode_wr, flag_wr, cfg_wr;
    logic reload_wr, compare_wr, live_wr;
    logic [31:0] rdata_d;
    art_pkg::art_mode_type mode;
    art_pkg::art_src_type src;
    logic src_tick, psc_tick, cnt_tick, active_edge, capture_evt;
    logic load_bit_evt, restart_evt, clr_evt, ext_load_evt;
    logic load_any, overflow, match_hit;
    logic [7:0] cnt_inc, cnt_after;
    logic [2:0] flag_set;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign pwm_output_pin_o = pwm_pin_q;
    assign irq_req_o = irq_q;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // one wait state; a transfer completes when pready is high
    assign apb_fire = psel_i & penable_i & pready_q;
    assign wr = apb_fire & pwrite_i;
    assign known = addr_hit(paddr_i, art_pkg::IDX_MODE)
        | addr_hit(paddr_i, art_pkg::IDX_FLAGS)
        | addr_hit(paddr_i, art_pkg::IDX_CLKSEL)
        | addr_hit(paddr_i, art_pkg::IDX_PRESCALER)
        | addr_hit(paddr_i, art_pkg::IDX_RELOAD)
        | addr_hit(paddr_i, art_pkg::IDX_COMPARE)
        | addr_hit(paddr_i, art_pkg::IDX_LIVE_LOAD);
    assign mode_wr = wr & addr_hit(paddr_i, art_pkg::IDX_MODE);
    assign flag_wr = wr & addr_hit(paddr_i, art_pkg::IDX_FLAGS);
    assign cfg_wr = wr & addr_hit(paddr_i, art_pkg::IDX_CLKSEL);
    assign reload_wr = wr & addr_hit(paddr_i, art_pkg::IDX_RELOAD);
    assign compare_wr = wr & addr_hit(paddr_i, art_pkg::IDX_COMPARE);
    assign live_wr = wr & addr_hit(paddr_i, art_pkg::IDX_LIVE_LOAD);

    // read mux; load bit and reserved bits read as zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (addr_hit(paddr_i, art_pkg::IDX_MODE))
            rdata_d = {25'h0, mode_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_FLAGS))
            rdata_d = {29'h0, flags_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_CLKSEL))
            rdata_d = {24'h0, cfg_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_PRESCALER))
            rdata_d = {25'h0, psc_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_RELOAD))
            rdata_d = {24'h0, reload_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_COMPARE))
            rdata_d = {24'h0, compare_q};
        else if (addr_hit(paddr_i, art_pkg::IDX_LIVE_LOAD))
            rdata_d = {24'h0, cnt_q};
    end

    // answer phase: ready, error and read data all from flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= psel_i & penable_i & ~pready_q;
            pslverr_q <= psel_i & penable_i & ~pready_q & ~known;
            if (psel_i & penable_i & ~pready_q & ~pwrite_i)
                prdata_q <= rdata_d;
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // mode control, clock select and compare
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= art_pkg::MODE_RESET[6:0];
            cfg_q <= art_pkg::CFG_RESET;
            compare_q <= art_pkg::BYTE_RESET;
        end
        else
        begin
            if (mode_wr)
                mode_q <= pwdata_i[6:0];
            if (cfg_wr)
            begin
                cfg_q <= pwdata_i[7:0];
                cfg_q[art_pkg::BIT_RSVD] <= 1'b0;
            end
            if (compare_wr)
                compare_q <= pwdata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // clock source, edge detect and prescaler tick
    // ------------------------------------------------------------
    assign mode = art_pkg::art_mode_type'(mode_q[art_pkg::MODE_LSB +: 2]);
    assign src = art_pkg::art_src_type'(cfg_q[art_pkg::CLK_LSB +: 2]);

    // divide-by-three phase counter and previous pin level
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div3_q <= 2'h0;
            evt_prev_q <= 1'b0;
        end
        else
        begin
            div3_q <= (div3_q == art_pkg::DIV3_LAST) ? 2'h0 : div3_q + 2'h1;
            evt_prev_q <= event_input_pin_i;
        end
    end

    // selected source ticks; reserved code never ticks
    always_comb
    begin
        case (src)
            art_pkg::ART_SRC_INT: src_tick = 1'b1;
            art_pkg::ART_SRC_DIV3: src_tick = (div3_q == art_pkg::DIV3_LAST);
            art_pkg::ART_SRC_PIN: src_tick = event_input_pin_i & ~evt_prev_q;
            default: src_tick = 1'b0;
        endcase
    end

    // active edge of the event pin per enable and polarity
    assign active_edge = cfg_q[art_pkg::BIT_EDGE_EN]
        & (cfg_q[art_pkg::BIT_EDGE_POL]
            ? (evt_prev_q & ~event_input_pin_i)
            : (~evt_prev_q & event_input_pin_i));

    // prescaler advances only while running; tick at 2^n
    assign psc_tick = mode_q[art_pkg::BIT_RUN] & src_tick;
    assign cnt_tick = psc_tick
        & ((psc_q & ps_mask(cfg_q[art_pkg::PS_LSB +: 3]))
            == ps_mask(cfg_q[art_pkg::PS_LSB +: 3]));

    // ------------------------------------------------------------
    // counter load and count decisions
    // ------------------------------------------------------------
    assign capture_evt = active_edge & ((mode == art_pkg::ART_CAPTURE)
        | (mode == art_pkg::ART_CAPTURE_RESET));
    assign clr_evt = active_edge & (mode == art_pkg::ART_CAPTURE_RESET);
    assign ext_load_evt = active_edge & (mode == art_pkg::ART_EXT_LOAD);
    assign load_bit_evt = mode_wr & pwdata_i[art_pkg::BIT_LOAD];
    assign restart_evt = mode_wr & (pwdata_i[6:0] == mode_q)
        & mode_q[art_pkg::BIT_PWM_OE] & mode_q[art_pkg::BIT_RUN];
    assign load_any = live_wr | load_bit_evt | restart_evt | clr_evt
        | ext_load_evt;
    assign overflow = cnt_tick & (cnt_q == art_pkg::COUNT_TOP);
    assign cnt_inc = cnt_q + 8'h01;
    assign cnt_after = (overflow && mode == art_pkg::ART_AUTO_RELOAD)
        ? reload_q : cnt_inc;
    assign match_hit = cnt_tick & ~load_any & (cnt_after == compare_q);

    // next counter and prescaler; any load clears the prescaler
    always_comb
    begin
        cnt_d = cnt_q;
        psc_d = psc_q;
        if (live_wr)
        begin
            cnt_d = pwdata_i[7:0];
            psc_d = 7'h00;
        end
        else if (load_bit_evt || restart_evt)
        begin
            cnt_d = reload_q;
            psc_d = 7'h00;
        end
        else if (clr_evt)
        begin
            cnt_d = 8'h00;
            psc_d = 7'h00;
        end
        else if (ext_load_evt)
        begin
            cnt_d = reload_q;
            psc_d = 7'h00;
        end
        else if (cnt_tick)
        begin
            cnt_d = cnt_after;
            psc_d = (overflow && mode == art_pkg::ART_AUTO_RELOAD)
                ? 7'h00 : psc_q + 7'h01;
        end
        else if (psc_tick)
            psc_d = psc_q + 7'h01;
    end

    // counter and prescaler storage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= art_pkg::BYTE_RESET;
            psc_q <= 7'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
            psc_q <= psc_d;
        end
    end

    // reload/capture register; a capture beats a software write
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reload_q <= art_pkg::BYTE_RESET;
        else if (capture_evt)
            reload_q <= cnt_q;
        else if (reload_wr)
            reload_q <= pwdata_i[7:0];
    end

    // ------------------------------------------------------------
    // flags, pwm and request
    // ------------------------------------------------------------
    assign flag_set[art_pkg::BIT_ROLL_FLAG] = overflow & ~load_any;
    assign flag_set[art_pkg::BIT_MATCH_FLAG] = match_hit;
    assign flag_set[art_pkg::BIT_EDGE_FLAG] = active_edge;

    // each flag: write zero clears, write one keeps, set wins
    for (genvar i = 0; i < 3; i++)
    begin : g_flag
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
                flags_q[i] <= art_pkg::FLAGS_RESET[i];
            else if (flag_set[i])
                flags_q[i] <= 1'b1;
            else if (flag_wr && !pwdata_i[i])
                flags_q[i] <= 1'b0;
        end
    end

    // pwm level: overflow sets, match clears, restart holds
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwm_q <= 1'b0;
        else if (match_hit)
            pwm_q <= 1'b0;
        else if (overflow && !load_any)
            pwm_q <= 1'b1;
    end

    // pin gating and request, both registered
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwm_pin_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            pwm_pin_q <= pwm_q & mode_q[art_pkg::BIT_PWM_OE];
            irq_q <= |(flags_q & mode_q[art_pkg::BIT_ROLL_IE +: 3]);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_match_ev;
        match_hit ##1 (mode_q[art_pkg::BIT_MATCH_IE] && !flag_wr);
    endsequence
    sequence s_auto_ovf;
        overflow && !load_any && mode == art_pkg::ART_AUTO_RELOAD;
    endsequence
    a_load_bit_copy: assert property (
        load_bit_evt && !live_wr |=> cnt_q == $past(reload_q) && psc_q == 0)
        else $error("load bit did not copy reload value");
    a_stop_freeze: assert property (
        !mode_q[art_pkg::BIT_RUN] && !load_any |=> $stable(cnt_q)
            && $stable(psc_q))
        else $error("stopped timer changed count");
    // a compare equal to the reload value clears the level at once
    a_auto_reload: assert property (
        s_auto_ovf |=> cnt_q == $past(reload_q)
            && flags_q[art_pkg::BIT_ROLL_FLAG] && pwm_q == !$past(match_hit))
        else $error("auto-reload overflow wrong");
    a_capture_copy: assert property (
        capture_evt |=> reload_q == $past(cnt_q)
            && flags_q[art_pkg::BIT_EDGE_FLAG])
        else $error("capture did not copy counter");
    a_capture_clear: assert property (
        clr_evt && !live_wr && !load_bit_evt && !restart_evt
            |=> cnt_q == 8'h00 && psc_q == 7'h00)
        else $error("capture-reset did not clear");
    a_ext_load: assert property (
        ext_load_evt && !live_wr && !load_bit_evt && !restart_evt
            |=> cnt_q == $past(reload_q) && psc_q == 7'h00)
        else $error("edge load did not copy reload");
    a_match_irq: assert property (
        s_match_ev |=> irq_req_o)
        else $error("match request missing");
    a_pwm_match_low: assert property (
        match_hit |=> !pwm_q ##1 !pwm_output_pin_o)
        else $error("match did not clear pwm");
    a_set_wins: assert property (
        flag_wr && flag_set[art_pkg::BIT_ROLL_FLAG]
            |=> flags_q[art_pkg::BIT_ROLL_FLAG])
        else $error("rollover event lost to clear");
    a_edge_kept: assert property (
        flag_wr && pwdata_i[art_pkg::BIT_EDGE_FLAG] |=> $past(active_edge)
            || $stable(flags_q[art_pkg::BIT_EDGE_FLAG]))
        else $error("edge flag changed by a one write");

endmodule : art_timer

`default_nettype wire

// ==== test/art_far_side.sv ====
// far-side model: event pin driver and pwm load monitor
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// far side of the timer pins
// ------------------------------------------------------------
module art_far_side (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_mode_i,
    input wire logic level_i,
    input wire logic pwm_i,
    output logic event_o,
    output int hi_w_o,
    output int lo_w_o,
    output int n_per_o
);
    logic pwm_q;
    int run_q;

    // event pin: free toggling clock or a held level
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            event_o <= 1'b0;
        else
            event_o <= clk_mode_i ? ~event_o : level_i;
    end

    // pwm load: widths of high and low phases in cycles
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwm_q <= 1'b0;
            run_q <= 0;
            hi_w_o <= 0;
            lo_w_o <= 0;
            n_per_o <= 0;
        end
        else
        begin
            pwm_q <= pwm_i;
            if (pwm_i === pwm_q)
                run_q <= run_q + 1;
            else
            begin
                run_q <= 1;
                if (pwm_q)
                    hi_w_o <= run_q;
                else
                begin
                    lo_w_o <= run_q;
                    n_per_o <= n_per_o + 1;
                end
            end
        end
    end
endmodule : art_far_side

`default_nettype wire

// ==== test/auto_reload_timer_modes_bench.sv ====
// self-checking bench of the auto-reload timer
`timescale 1ns/100ps
`default_nettype none

module auto_reload_timer_modes_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_clk = 1'b0;
    logic pin_lvl = 1'b0;
    logic ev_pin;
    logic pwm;
    logic irq;
    int hi_w;
    int lo_w;
    int n_per;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] rd_q;
    logic err_q;

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    art_timer #(.ADDR_W(12)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .event_input_pin_i(ev_pin),
        .pwm_output_pin_o(pwm), .irq_req_o(irq)
    );

    art_far_side far (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_mode_i(pin_clk),
        .level_i(pin_lvl), .pwm_i(pwm), .event_o(ev_pin),
        .hi_w_o(hi_w), .lo_w_o(lo_w), .n_per_o(n_per)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr_en, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        rd_q = prdata;
        err_q = pslverr;
        if (n >= 20)
            mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h00000000);
        check(rd_q, exp);
    endtask : rdc

    // drive the event pin level and let the edge settle
    task automatic pin(input logic v);
        @(posedge clk_i);
        pin_lvl <= v;
        repeat (4) @(posedge clk_i);
    endtask : pin

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int srcs[4] = '{0, 0, 1, 2};
        int ns[4] = '{0, 2, 1, 0};
        int facs[4] = '{1, 1, 3, 2};
        int rel;
        int cmp;
        int dv;
        int p0;
        int k;
        int seed_v;
        seed_v = $urandom(26806);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(art_pkg::IDX_MODE, 32'h00);
        rdc(art_pkg::IDX_FLAGS, 32'h00);
        apb(1'b0, 8'hE0, 32'h00);
        check(err_q, 32'h1);
        wr(art_pkg::IDX_RELOAD, 32'h10);
        wr(art_pkg::IDX_MODE, 32'h80);
        rdc(art_pkg::IDX_LIVE_LOAD, 32'h10);
        rdc(art_pkg::IDX_MODE, 32'h00);
        repeat (20) @(posedge clk_i);
        rdc(art_pkg::IDX_LIVE_LOAD, 32'h10);
        // pwm widths for the internal, divide-by-three and pin sources, with prescales 0, 1 and 2
        for (int c = 0; c < 4; c++)
        begin
            wr(art_pkg::IDX_MODE, 32'h00);
            pin_clk <= (srcs[c] == 2);
            wr(art_pkg::IDX_CLKSEL, 32'((ns[c] << 5) | srcs[c]));
            rel = $urandom_range(0, 192);
            cmp = rel + 1 + $urandom_range(0, 254 - rel);
            wr(art_pkg::IDX_RELOAD, 32'(rel));
            wr(art_pkg::IDX_COMPARE, 32'(cmp));
            wr(art_pkg::IDX_MODE, 32'hE0);
            p0 = n_per;
            k = 0;
            while (n_per < p0 + 3 && k < 30000)
            begin
                @(posedge clk_i);
                k++;
            end
            if (k >= 30000)
                mismatches++;
            dv = facs[c] << ns[c];
            check(hi_w, 32'((cmp - rel) * dv));
            check(lo_w, 32'((256 - cmp) * dv));
        end
        wr(art_pkg::IDX_MODE, 32'h40);
        repeat (5) @(posedge clk_i);
        p0 = n_per;
        repeat (600) @(posedge clk_i);
        check(32'(n_per - p0), 32'h0);
        check(pwm, 32'h0);
        wr(art_pkg::IDX_MODE, 32'h00);
        pin_clk <= 1'b0;
        rdc(art_pkg::IDX_FLAGS, 32'h03);
        // requests, masking and flag clearing
        wr(art_pkg::IDX_MODE, 32'h04);
        repeat (3) @(posedge clk_i);
        check(irq, 32'h1);
        wr(art_pkg::IDX_FLAGS, 32'h07);
        rdc(art_pkg::IDX_FLAGS, 32'h03);
        wr(art_pkg::IDX_FLAGS, 32'h06);
        rdc(art_pkg::IDX_FLAGS, 32'h02);
        check(irq, 32'h0);
        wr(art_pkg::IDX_MODE, 32'h08);
        repeat (3) @(posedge clk_i);
        check(irq, 32'h1);
        wr(art_pkg::IDX_FLAGS, 32'h00);
        rdc(art_pkg::IDX_FLAGS, 32'h00);
        // capture mode, rising then falling edges
        wr(art_pkg::IDX_CLKSEL, 32'h04);
        wr(art_pkg::IDX_MODE, 32'h11);
        wr(art_pkg::IDX_LIVE_LOAD, 32'h5A);
        wr(art_pkg::IDX_RELOAD, 32'h33);
        pin(1'b1);
        rdc(art_pkg::IDX_RELOAD, 32'h5A);
        rdc(art_pkg::IDX_FLAGS, 32'h04);
        check(irq, 32'h1);
        wr(art_pkg::IDX_FLAGS, 32'h00);
        wr(art_pkg::IDX_LIVE_LOAD, 32'h11);
        pin(1'b0);
        rdc(art_pkg::IDX_RELOAD, 32'h5A);
        rdc(art_pkg::IDX_FLAGS, 32'h00);
        wr(art_pkg::IDX_CLKSEL, 32'h0C);
        pin(1'b1);
        pin(1'b0);
        rdc(art_pkg::IDX_RELOAD, 32'h11);
        // capture with counter reset
        wr(art_pkg::IDX_CLKSEL, 32'h04);
        wr(art_pkg::IDX_MODE, 32'h02);
        wr(art_pkg::IDX_LIVE_LOAD, 32'h44);
        pin(1'b1);
        rdc(art_pkg::IDX_RELOAD, 32'h44);
        rdc(art_pkg::IDX_LIVE_LOAD, 32'h00);
        // load on external edge
        wr(art_pkg::IDX_MODE, 32'h03);
        wr(art_pkg::IDX_RELOAD, 32'h77);
        pin(1'b0);
        pin(1'b1);
        rdc(art_pkg::IDX_LIVE_LOAD, 32'h77);
        // match request while counting; 06h keeps the edge flag
        wr(art_pkg::IDX_CLKSEL, 32'h00);
        wr(art_pkg::IDX_COMPARE, 32'h80);
        wr(art_pkg::IDX_MODE, 32'hC8);
        repeat (20) @(posedge clk_i);
        check(irq, 32'h1);
        wr(art_pkg::IDX_MODE, 32'h08);
        wr(art_pkg::IDX_FLAGS, 32'h06);
        rdc(art_pkg::IDX_FLAGS, 32'h06);
        tally_and_finish();
    end

    // watchdog against a hung handshake
    initial
    begin
        #(50 * 80000);
        mismatches++;
        tally_and_finish();
    end
endmodule : auto_reload_timer_modes_bench

`default_nettype wire
